// >>> design/mcrb_serial_slave.sv
// Two-wire serial slave engine: byte framing, acknowledge and word assembly.
// Assumes scl and sda arrive asynchronously; both are double-flopped here.
`timescale 1ns/1ps
module mcrb_serial_slave
    import mcrb_pkg::*;
(
    input  wire logic        clk,         // System clock
    input  wire logic        rst_n,       // Synchronised reset, active low
    input  wire logic        scl_in,      // Bus clock pin
    input  wire logic        sda_in,      // Bus data pin level
    output logic             sda_oe,      // High while pulling data low
    output logic [7:0]       reg_ptr,     // Register pointer set by host
    input  wire logic [15:0] rd_word,     // Word at reg_ptr
    output logic             wr_pulse,    // One-cycle write strobe
    output logic [15:0]      wr_word      // Word to write
);
    logic [1:0]      scl_sync_reg;
    logic [1:0]      sda_sync_reg;
    logic            scl_prev_reg;
    logic            sda_prev_reg;
    mcrb_bus_state_t state_reg;
    logic [3:0]      bit_cnt_reg;
    logic [1:0]      byte_idx_reg;
    logic [7:0]      shift_reg;
    logic [7:0]      hi_byte_reg;
    logic [15:0]     tx_reg;
    logic            read_reg;
    logic            lo_sent_reg;
    logic            mack_ok_reg;
    logic            scl_rise;
    logic            scl_fall;
    logic            start_det;
    logic            stop_det;

    // Two flops ahead of any logic; edge history taken from the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], scl_in};
            sda_sync_reg <= {sda_sync_reg[0], sda_in};
            scl_prev_reg <= scl_sync_reg[1];
            sda_prev_reg <= sda_sync_reg[1];
        end
    end

    assign scl_rise  = scl_sync_reg[1] & ~scl_prev_reg;
    assign scl_fall  = ~scl_sync_reg[1] & scl_prev_reg;
    assign start_det = scl_sync_reg[1] & scl_prev_reg & sda_prev_reg & ~sda_sync_reg[1];
    assign stop_det  = scl_sync_reg[1] & scl_prev_reg & ~sda_prev_reg & sda_sync_reg[1];

    // Protocol sequencer; start or stop aborts anything in flight
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg    <= BUS_IDLE;
            bit_cnt_reg  <= 4'h0;
            byte_idx_reg <= 2'h0;
            shift_reg    <= 8'h00;
            hi_byte_reg  <= 8'h00;
            tx_reg       <= 16'h0000;
            read_reg     <= 1'b0;
            lo_sent_reg  <= 1'b0;
            mack_ok_reg  <= 1'b0;
            sda_oe       <= 1'b0;
            reg_ptr      <= 8'h00;
            wr_pulse     <= 1'b0;
            wr_word      <= 16'h0000;
        end else begin
            wr_pulse <= 1'b0;
            if (start_det) begin
                state_reg    <= BUS_RX;
                bit_cnt_reg  <= 4'h0;
                byte_idx_reg <= 2'h0;
                sda_oe       <= 1'b0;
            end else if (stop_det) begin
                state_reg <= BUS_IDLE;
                sda_oe    <= 1'b0;
            end else begin
                case (state_reg)
                    BUS_RX: begin
                        if (scl_rise) begin
                            shift_reg   <= {shift_reg[6:0], sda_sync_reg[1]};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                            bit_cnt_reg <= 4'h0;
                            state_reg   <= BUS_ACK;
                            sda_oe      <= 1'b1;
                            byte_idx_reg <= (byte_idx_reg == 2'h3) ? 2'h2 : byte_idx_reg + 2'h1;
                            case (byte_idx_reg)
                                2'h0: begin
                                    if (shift_reg[7:1] != DEV_BUS_ADDR) begin
                                        state_reg <= BUS_IDLE; // Not ours: no acknowledge
                                        sda_oe    <= 1'b0;
                                    end
                                    read_reg <= shift_reg[0];
                                end
                                2'h1: reg_ptr <= shift_reg;
                                2'h2: hi_byte_reg <= shift_reg; // High byte comes first
                                default: begin
                                    wr_word  <= {hi_byte_reg, shift_reg};
                                    wr_pulse <= 1'b1;
                                end
                            endcase
                        end
                    end
                    BUS_ACK: begin
                        if (scl_fall) begin
                            if (read_reg) begin
                                // Word captured once so both bytes come from one value
                                sda_oe      <= ~rd_word[15];
                                tx_reg      <= {rd_word[14:0], 1'b0};
                                bit_cnt_reg <= 4'h1;
                                lo_sent_reg <= 1'b0;
                                state_reg   <= BUS_TX;
                            end else begin
                                sda_oe    <= 1'b0;
                                state_reg <= BUS_RX;
                            end
                        end
                    end
                    BUS_TX: begin
                        if (scl_fall) begin
                            if (bit_cnt_reg == 4'h8) begin
                                sda_oe    <= 1'b0;
                                state_reg <= BUS_MACK;
                            end else begin
                                sda_oe      <= ~tx_reg[15];
                                tx_reg      <= {tx_reg[14:0], 1'b0};
                                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                            end
                        end
                    end
                    BUS_MACK: begin
                        if (scl_rise) begin
                            mack_ok_reg <= ~sda_sync_reg[1];
                        end else if (scl_fall) begin
                            if (mack_ok_reg && !lo_sent_reg) begin
                                sda_oe      <= ~tx_reg[15]; // Low byte follows
                                tx_reg      <= {tx_reg[14:0], 1'b0};
                                bit_cnt_reg <= 4'h1;
                                lo_sent_reg <= 1'b1;
                                state_reg   <= BUS_TX;
                            end else begin
                                state_reg <= BUS_IDLE;
                            end
                        end
                    end
                    default: state_reg <= BUS_IDLE;
                endcase
            end
        end
    end
endmodule

// >>> design/mcrb_top.sv
// Motor configuration register bank: EEPROM mirror, host access and field decode.
// Assumes an EEPROM read port whose data stands while ee_rd_en is high.
`timescale 1ns/1ps
module mcrb_top
    import mcrb_pkg::*;
(
    input  wire logic        clk,          // 20 MHz system clock
    input  wire logic        resetn,       // Asynchronous reset, active low
    input  wire logic        scl_in,       // Serial bus clock pin
    input  wire logic        sda_in,       // Serial bus data pin level
    output logic             sda_out,      // Data drive level, always low
    output logic             sda_oe,       // High while pulling data low
    output logic             ee_rd_en,     // EEPROM word read strobe
    output logic [4:0]       ee_addr,      // EEPROM word address
    input  wire logic [15:0] ee_rd_data,   // EEPROM word, while strobed
    output logic             load_done,    // Power-on copy finished
    output mcrb_cfg_t        cfg           // Decoded operating parameters
);
    logic [1:0]       rst_sync_reg;
    logic             rst_n;
    mcrb_load_state_t ld_state_reg;
    logic [15:0]      mem_reg [NUM_REGS];
    logic [7:0]       reg_ptr;
    logic [15:0]      rd_word;
    logic             wr_pulse;
    logic [15:0]      wr_word;
    logic             sda_oe_eng;
    logic [4:0]       cap_idx;
    logic [7:0]       wr_idx;
    logic             wr_hit;
    mcrb_cfg_t        cfg_next;

    // Reset released through two flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // Power-on copy of EEPROM words into the mirror
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ld_state_reg <= LD_REQ;
            ee_addr      <= EE_FIRST_WORD;
            ee_rd_en     <= 1'b0;
            load_done    <= 1'b0;
        end else begin
            case (ld_state_reg)
                LD_REQ: begin
                    ee_rd_en     <= 1'b1;
                    ld_state_reg <= LD_CAP;
                end
                LD_CAP: begin
                    ee_rd_en <= 1'b0;
                    if (ee_addr == EE_LAST_WORD) begin
                        ld_state_reg <= LD_DONE;
                        load_done    <= 1'b1;
                    end else begin
                        ee_addr      <= ee_addr + 5'h01;
                        ld_state_reg <= LD_REQ;
                    end
                end
                LD_DONE: ld_state_reg <= LD_DONE;
                default: ld_state_reg <= LD_REQ;
            endcase
        end
    end

    // EEPROM word n lands in register n plus 64, bit for bit
    assign cap_idx = ee_addr - EE_FIRST_WORD;
    assign wr_idx  = reg_ptr - (8'({3'h0, EE_FIRST_WORD}) + EE_TO_REG_OFFSET);
    assign wr_hit  = wr_pulse && (reg_ptr >= SPEED_LOOP_CFG_ADDR) && (reg_ptr <= LAST_REG_ADDR);

    // Mirror storage; load has priority, host writes ignored until it ends
    generate
        for (genvar i = 0; i < NUM_REGS; i++) begin : g_word
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    mem_reg[i] <= 16'h0000;
                end else if (ld_state_reg == LD_CAP && cap_idx == 5'(i)) begin
                    mem_reg[i] <= ee_rd_data;
                end else if (load_done && wr_hit && wr_idx == 8'(i)) begin
                    mem_reg[i] <= wr_word; // All bits stored
                end
            end
        end
    endgenerate

    // Readback; unmapped addresses read zero
    always_comb begin
        rd_word = 16'h0000;
        if (reg_ptr >= SPEED_LOOP_CFG_ADDR && reg_ptr <= LAST_REG_ADDR) begin
            rd_word = mem_reg[4'(reg_ptr - SPEED_LOOP_CFG_ADDR)];
        end
    end

    mcrb_serial_slave u_slave (
        .clk      (clk),
        .rst_n    (rst_n),
        .scl_in   (scl_in),
        .sda_in   (sda_in),
        .sda_oe   (sda_oe_eng),
        .reg_ptr  (reg_ptr),
        .rd_word  (rd_word),
        .wr_pulse (wr_pulse),
        .wr_word  (wr_word)
    );

    // Open-drain pin: only ever pulled low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_out <= 1'b0;
            sda_oe  <= 1'b0;
        end else begin
            sda_out <= 1'b0;
            sda_oe  <= sda_oe_eng;
        end
    end

    // Field decode; only documented fields are read, so spare bits are inert
    always_comb begin
        logic [7:0]  volt_code;
        logic [7:0]  sense_code;
        logic [10:0] cur_code;
        logic [2:0]  start_code;
        logic [5:0]  ratio_code;
        logic [17:0] cur_num;
        logic [20:0] res_prod;
        logic [20:0] start_prod;
        volt_code  = mem_reg[IDX_RATING][VOLT_MSB:0];
        sense_code = mem_reg[IDX_RATING][SENSE_MSB:SENSE_LSB];
        cur_code   = mem_reg[IDX_CURRENT][RATED_CUR_MSB:0];
        start_code = mem_reg[IDX_CURRENT][START_CUR_MSB:START_CUR_LSB];
        ratio_code = mem_reg[IDX_RATIO][RATIO_MSB:0];
        cur_num    = 18'(cur_code) * SENSE_DIVISOR;
        res_prod   = 21'(mem_reg[IDX_ACCEL][RES_MSB:RES_LSB]) * 21'(sense_code) * RES_MOHM_MULT;
        cfg_next   = '0;

        // Tenths of a volt: code/5 volts
        cfg_next.rated_voltage_dv = 9'(volt_code) * VOLT_DV_PER_CODE;
        cfg_next.rated_speed_mhz  = 21'(mem_reg[IDX_SPEED][RATED_SPEED_MSB:0]) * SPEED_MHZ_PER_CODE;
        // Zero sense code would divide by zero; saturate instead
        cfg_next.rated_current_ma = (sense_code == 8'h00) ? '1 : cur_num / 18'(sense_code);
        // code*sense/5120 ohms expressed in milliohms
        cfg_next.resistance_mohm  = 14'(res_prod >> RES_MOHM_SHIFT);
        start_prod = 21'(cfg_next.rated_current_ma) * 21'({1'b0, start_code} + 4'h1);
        cfg_next.startup_cur_valid  = (start_code != 3'h0);
        cfg_next.startup_current_ma = (start_code == 3'h0) ? 18'h00000
                                      : 18'(start_prod >> START_CUR_SHIFT);
        cfg_next.accel_mhz_per_s  = 20'(mem_reg[IDX_ACCEL][ACCEL_MSB:0])
                                    * (mem_reg[IDX_SPEED][ACCEL_RANGE_BIT] ? ACCEL_COARSE_MHZ
                                                                           : ACCEL_FINE_MHZ);
        cfg_next.closed_loop       = mem_reg[IDX_SPEED][CLOSED_LOOP_BIT];
        cfg_next.input_kind_select = mem_reg[IDX_CURRENT][INPUT_KIND_BIT];
        // Pulse kind only matters when the digital input is selected
        cfg_next.digital_freq_cmd  = ~mem_reg[IDX_CURRENT][INPUT_KIND_BIT]
                                     & mem_reg[IDX_SPEED][DIGITAL_FREQ_BIT];
        cfg_next.duty_input_band   = mem_reg[IDX_SPEED][DUTY_BAND_BIT];
        cfg_next.direction_abc     = mem_reg[IDX_SPEED][DIRECTION_BIT];
        // Out-of-range ratio clamped rather than trusted
        cfg_next.ratio_rpm_hz_x100 = 11'((ratio_code > RATIO_MAX_CODE) ? RATIO_MAX_CODE : ratio_code)
                                     * RATIO_X100_STEP;
        cfg_next.deadtime_ns       = (10'(mem_reg[IDX_SOFT][DEADTIME_MSB:DEADTIME_LSB]) + 10'h001)
                                     * DEADTIME_STEP;
        cfg_next.soft_on           = mem_reg[IDX_SOFT][SOFT_ON_BIT];
        cfg_next.soft_off          = mem_reg[IDX_SOFT][SOFT_OFF_BIT];
        cfg_next.fg_pin_dis        = mem_reg[IDX_TACH][FG_DIS_BIT];
        cfg_next.host_speed_mode   = mem_reg[IDX_HOSTSPD][HOST_SPD_BIT];
        cfg_next.host_speed_demand = mem_reg[IDX_HOSTSPD][SPD_DEMAND_MSB:0];
        cfg_next.brake_mode        = mem_reg[IDX_RATIO][BRAKE_MODE_BIT];
        cfg_next.deadtime_comp     = mem_reg[IDX_RATIO][DT_COMP_BIT];
    end

    // Decoded view registered; a write shows here one cycle later
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= '0;
        end else begin
            cfg <= cfg_next;
        end
    end
endmodule

// >>> dv/mcrb_ee_model.sv
// EEPROM model: the addressed word stands while the strobe is high.
// Assumes the bench knows the fixed word pattern.
`timescale 1ns/1ps
module mcrb_ee_model (
    input  wire logic        rd_en, // Read strobe
    input  wire logic [4:0]  addr,  // Word address
    output logic      [15:0] data   // Word, while strobed
);
    // Off-strobe data inverts so a late sample fails
    always_comb begin
        data = (16'h9e37 * addr) ^ 16'h0c5a;
        if (!rd_en) data = ~data;
    end
endmodule

// >>> dv/mcrb_props.sv
// Port checks for the register bank top module.
// Assumes a bind to mcrb_top; one clock domain.
`timescale 1ns/1ps
module mcrb_props
    import mcrb_pkg::*;
(
    input wire logic       clk,       // Clock
    input wire logic       resetn,    // Reset, active low
    input wire logic       sda_out,   // Data drive level
    input wire logic       ee_rd_en,  // EEPROM strobe
    input wire logic [4:0] ee_addr,   // EEPROM address
    input wire logic       load_done, // Copy finished
    input wire mcrb_cfg_t  cfg        // Decoded fields
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // A load step is a strobe and then one quiet cycle
    sequence load_step;
        ee_rd_en ##1 !ee_rd_en;
    endsequence
    chk_drive_low: assert property (sda_out == 1'b0)
        else $error("sda drive level high");
    chk_strobe_pulse: assert property (ee_rd_en |-> load_step)
        else $error("strobe longer than one cycle");
    chk_load_walk: assert property (ee_rd_en && ee_addr != 5'h16 |->
        load_step ##1 (ee_rd_en && ee_addr == $past(ee_addr, 2) + 5'h01)) else $error("load step out of order");
    chk_addr_range: assert property (ee_rd_en |-> ee_addr >= 5'h08 && ee_addr <= 5'h16)
        else $error("EEPROM address out of range");
    chk_load_end: assert property (ee_rd_en && ee_addr == 5'h16 |-> ##[1:4] load_done)
        else $error("load not finished");
    chk_done_holds: assert property (load_done |=> load_done && !ee_rd_en)
        else $error("load restarted");
    chk_dead_step: assert property ($past(load_done, 4) |-> cfg.deadtime_ns % 10'd40 == 0 &&
        cfg.deadtime_ns != 0 && cfg.deadtime_ns <= 10'd640) else $error("dead time off grid");
    chk_ratio_clamp: assert property (cfg.ratio_rpm_hz_x100 <= 11'd1050)
        else $error("ratio above limit");
    chk_start_none: assert property (!cfg.startup_cur_valid |-> cfg.startup_current_ma == 18'h0)
        else $error("startup current without code");
endmodule
bind mcrb_top mcrb_props i_mcrb_props (.clk(clk), .resetn(resetn), .sda_out(sda_out),
    .ee_rd_en(ee_rd_en), .ee_addr(ee_addr), .load_done(load_done), .cfg(cfg));

// >>> dv/test_mcrb_top.sv
// Bench: bit-banged host on the serial pins, EEPROM model, decode checks.
// Assumes the checker binds itself to mcrb_top.
`timescale 1ns/1ps
module test_mcrb_top;
    import mcrb_pkg::*;
    logic clk = 0, resetn = 0, scl = 1, sda_h = 1, nak = 0, sda_oe, sda_out, ee_rd_en, load_done;
    logic [4:0] ee_addr;
    logic [7:0] p, q;
    logic [15:0] ee_rd_data, w, d, sh [NUM_REGS];
    logic [23:0] cs [5] = '{24'h4f0000, 24'h4f0f00, 24'h56002a, 24'h48ffff, 24'h4a0800};
    mcrb_cfg_t cfg;
    int error_cnt = 0, check_count = 0, cyc = 0, seed = 34;
    wire sda = sda_oe ? 1'b0 : sda_h;
    always #25 clk = ~clk;
    mcrb_top i_mcrb_top (.clk(clk), .resetn(resetn), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .ee_rd_en(ee_rd_en), .ee_addr(ee_addr), .ee_rd_data(ee_rd_data),
        .load_done(load_done), .cfg(cfg));
    mcrb_ee_model i_mcrb_ee_model (.rd_en(ee_rd_en), .addr(ee_addr), .data(ee_rd_data));
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            error_cnt++;
            stop_test();
        end
    end
    task automatic tk(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic cmp(input string s, input logic [95:0] e, g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("FAIL %s exp %h got %h", s, e, g);
        end
    endtask
    // One bus bit; scl phases kept at 8 cycles or more
    task automatic bt(input logic b, output logic r);
        tk(2);
        sda_h = b;
        tk(6);
        scl = 1;
        tk(4);
        r = sda;
        tk(4);
        scl = 0;
    endtask
    // Start when v is 1, stop when v is 0
    task automatic ev(input logic v);
        tk(2);
        sda_h = v;
        tk(6);
        scl = 1;
        tk(8);
        sda_h = ~v;
        tk(8);
        scl = ~v;
    endtask
    task automatic by(input logic [7:0] b, input logic m, output logic [7:0] r);
        logic a;
        for (int i = 7; i >= 0; i--) bt(b[i], r[i]);
        bt(m, a);
        if (m && b != 8'hff) nak |= a;
    endtask
    // High byte first in both directions
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        ev(1);
        by(8'haa, 1, q);
        by(a, 1, q);
        by(v[15:8], 1, q);
        by(v[7:0], 1, q);
        ev(0);
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        ev(1);
        by(8'haa, 1, q);
        by(a, 1, q);
        ev(0);
        ev(1);
        by(8'hab, 1, q);
        by(8'hff, 0, v[15:8]);
        by(8'hff, 1, v[7:0]);
        ev(0);
    endtask
    task automatic chk();
        logic [17:0] ic;
        logic [2:0] n;
        n = sh[2][15:13];
        ic = sh[12][15:8] == 0 ? '1 : 18'((32'(sh[2][10:0]) * 125) / sh[12][15:8]);
        tk(20);
        cmp("scale", {cfg.rated_voltage_dv, cfg.rated_speed_mhz, cfg.rated_current_ma, cfg.startup_current_ma},
            {9'(sh[12][7:0] * 2), 21'(sh[0][10:0] * 530), ic, n == 0 ? 18'h0 : 18'((32'(ic) * (n + 1)) >> 3)});
        cmp("mode", {cfg.accel_mhz_per_s, cfg.closed_loop, cfg.input_kind_select, cfg.digital_freq_cmd,
            cfg.duty_input_band, cfg.startup_cur_valid}, {20'(sh[1][7:0] * (sh[0][13] ? 3200 : 50)), sh[0][11],
            sh[2][11], sh[0][12] & ~sh[2][11], sh[0][15], |n});
        cmp("dt_ratio", {cfg.deadtime_ns, cfg.ratio_rpm_hz_x100}, {10'((sh[7][11:8] + 1) * 40),
            sh[14][5:0] > 42 ? 11'd1050 : 11'(sh[14][5:0] * 25)});
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Main sequence: load, corners then random writes, refusals
    initial begin
        tk(12);
        resetn = 1;
        for (int i = 0; i < NUM_REGS; i++) sh[i] = (16'h9e37 * 16'(i + 8)) ^ 16'h0c5a;
        for (int i = 0; i < 200 && load_done !== 1'b1; i++) tk(1);
        cmp("load_done", 1, load_done);
        chk();
        $display("load test done");
        for (int k = 0; k < 17; k++) begin
            {p, w} = k < 5 ? cs[k] : {8'h48 + 8'($unsigned($random(seed)) % 15), 16'($random(seed))};
            if (p == 8'h56) w[5:0] = w[5:0] % 43;
            if (p == 8'h54) w[8] = 1'b1;
            wr(p, w);
            sh[p - 8'h48] = w;
            rd(p, d);
            cmp("readback", w, d);
            chk();
        end
        cmp("acks", 0, nak);
        $display("access test done");
        wr(8'h47, 16'h1234);
        rd(8'h47, d);
        cmp("unmapped", 0, d);
        ev(1);
        by(8'h20, 1, q);
        ev(0);
        cmp("foreign_nak", 1, nak);
        $display("refusal test done");
        stop_test();
    end
endmodule

// >>> include/mcrb_pkg.sv
// Constants, field layout and carrier types of the motor configuration register bank.
// Assumes one 20 MHz clock and a word-wide EEPROM read port answering while strobed.
// Functional notes
// - Rated voltage equals the eight-bit voltage code divided by five.
// - Rated electrical frequency in hertz equals the speed code times 0.530.
// - Rated current in mA equals current code over (sense code over 125).
// - Winding resistance scales by resistance and sense codes, ohms = code*sense/5120.
// - Startup current code zero means none; else rated*(code+1)/8.
// - Acceleration equals code times 0.05 Hz/s, or 3.2 Hz/s with range set.
// - Loop-select bit one gives closed-loop speed control, zero gives open loop.
// - Input-kind bit one takes analog speed, zero takes digital pulse input.
// - For digital input, one means frequency command, zero means duty-cycle command.
// - Duty input band bit one expects at most 2.8 kHz, zero above.
// - Ratio code times 0.25 gives rpm per hertz; host keeps code at 42 or less.
// - Bus address of each register is its EEPROM word address plus 64.
// - EEPROM words load at power-on; later host writes take effect at once.
// - Each transfer carries sixteen bits as two bytes, high byte first.
package mcrb_pkg;

    // Address map
    localparam logic [7:0] EE_TO_REG_OFFSET = 8'h40;
    localparam logic [4:0] EE_FIRST_WORD    = 5'h08;
    localparam logic [4:0] EE_LAST_WORD     = 5'h16;
    localparam int         NUM_REGS         = 15;
    localparam logic [6:0] DEV_BUS_ADDR     = 7'h55;

    localparam logic [7:0] SPEED_LOOP_CFG_ADDR        = 8'h48;
    localparam logic [7:0] ACCEL_RESISTANCE_CFG_ADDR  = 8'h49;
    localparam logic [7:0] CURRENT_INPUT_CFG_ADDR     = 8'h4a;
    localparam logic [7:0] STARTUP_CFG_ADDR           = 8'h4b;
    localparam logic [7:0] OBSERVER_PROP_GAIN_ADDR    = 8'h4c;
    localparam logic [7:0] OBSERVER_INTEGRAL_GAIN_ADDR = 8'h4d;
    localparam logic [7:0] TACH_OUTPUT_CFG_ADDR       = 8'h4e;
    localparam logic [7:0] SOFT_SWITCH_DEADTIME_ADDR  = 8'h4f;
    localparam logic [7:0] PROTECTION_BUFFER_CFG_ADDR = 8'h50;
    localparam logic [7:0] HOST_SPEED_COMMAND_ADDR    = 8'h51;
    localparam logic [7:0] GATE_SLEW_PROBE_CFG_ADDR   = 8'h52;
    localparam logic [7:0] FET_CAP_COMP_CFG_ADDR      = 8'h53;
    localparam logic [7:0] VOLTAGE_SHUNT_RATING_ADDR  = 8'h54;
    localparam logic [7:0] INPUT_THRESHOLD_STBY_ADDR  = 8'h55;
    localparam logic [7:0] RATIO_RESTART_BRAKE_ADDR   = 8'h56;
    localparam logic [7:0] LAST_REG_ADDR              = 8'h56;

    // Register indices (address minus first address)
    localparam int IDX_SPEED   = 0;
    localparam int IDX_ACCEL   = 1;
    localparam int IDX_CURRENT = 2;
    localparam int IDX_SOFT    = 7;
    localparam int IDX_HOSTSPD = 9;
    localparam int IDX_RATING  = 12;
    localparam int IDX_RATIO   = 14;
    localparam int IDX_TACH    = 6;

    // Field positions
    localparam int RATED_SPEED_MSB = 10;
    localparam int CLOSED_LOOP_BIT = 11;
    localparam int DIGITAL_FREQ_BIT = 12;
    localparam int ACCEL_RANGE_BIT = 13;
    localparam int DIRECTION_BIT   = 14;
    localparam int DUTY_BAND_BIT   = 15;
    localparam int ACCEL_MSB       = 7;
    localparam int RES_LSB         = 8;
    localparam int RES_MSB         = 15;
    localparam int RATED_CUR_MSB   = 10;
    localparam int INPUT_KIND_BIT  = 11;
    localparam int START_CUR_LSB   = 13;
    localparam int START_CUR_MSB   = 15;
    localparam int FG_DIS_BIT      = 4;
    localparam int SOFT_OFF_BIT    = 6;
    localparam int SOFT_ON_BIT     = 7;
    localparam int DEADTIME_LSB    = 8;
    localparam int DEADTIME_MSB    = 11;
    localparam int SPD_DEMAND_MSB  = 8;
    localparam int HOST_SPD_BIT    = 9;
    localparam int VOLT_MSB        = 7;
    localparam int SENSE_LSB       = 8;
    localparam int SENSE_MSB       = 15;
    localparam int RATIO_MSB       = 5;
    localparam int BRAKE_MODE_BIT  = 8;
    localparam int DT_COMP_BIT     = 12;

    // Scaling constants
    localparam logic [8:0]  VOLT_DV_PER_CODE   = 9'h002;
    localparam logic [20:0] SPEED_MHZ_PER_CODE = 21'd530;
    localparam logic [17:0] SENSE_DIVISOR      = 18'd125;
    localparam logic [20:0] RES_MOHM_MULT      = 21'd25;
    localparam int          RES_MOHM_SHIFT     = 7;
    localparam int          START_CUR_SHIFT    = 3;
    localparam logic [19:0] ACCEL_FINE_MHZ     = 20'd50;
    localparam logic [19:0] ACCEL_COARSE_MHZ   = 20'd3200;
    localparam logic [10:0] RATIO_X100_STEP    = 11'd25;
    localparam logic [5:0]  RATIO_MAX_CODE     = 6'd42;
    localparam int          DEADTIME_STEP_NS   = 40;
    localparam logic [9:0]  DEADTIME_STEP      = 10'(DEADTIME_STEP_NS);

    typedef enum logic [1:0] {
        LD_REQ  = 2'b00,
        LD_CAP  = 2'b01,
        LD_DONE = 2'b10
    } mcrb_load_state_t;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b000,
        BUS_RX   = 3'b001,
        BUS_ACK  = 3'b010,
        BUS_TX   = 3'b011,
        BUS_MACK = 3'b100
    } mcrb_bus_state_t;

    // Decoded operating parameters handed to the motor core
    typedef struct packed {
        logic [8:0]  rated_voltage_dv;
        logic [20:0] rated_speed_mhz;
        logic [17:0] rated_current_ma;
        logic [13:0] resistance_mohm;
        logic        startup_cur_valid;
        logic [17:0] startup_current_ma;
        logic [19:0] accel_mhz_per_s;
        logic        closed_loop;
        logic        input_kind_select;
        logic        digital_freq_cmd;
        logic        duty_input_band;
        logic        direction_abc;
        logic [10:0] ratio_rpm_hz_x100;
        logic [9:0]  deadtime_ns;
        logic        soft_on;
        logic        soft_off;
        logic        fg_pin_dis;
        logic        host_speed_mode;
        logic [8:0]  host_speed_demand;
        logic        brake_mode;
        logic        deadtime_comp;
    } mcrb_cfg_t;

endpackage
